// File: rtl/tws_pkg.sv
package tws_pkg;

  // Mode field encodings
  localparam logic [3:0] MODE_SLV7 = 4'h6;
  localparam logic [3:0] MODE_SLV10 = 4'h7;
  localparam logic [3:0] MODE_MST = 4'h8;
  localparam logic [3:0] MODE_FWMST = 4'hb;
  localparam logic [3:0] MODE_SLV7_SS = 4'he;
  localparam logic [3:0] MODE_SLV10_SS = 4'hf;

  // Configuration vector carried into the link domain
  localparam int CFG_W = 5;
  localparam int CFG_EN = 0;
  localparam int CFG_SLAVE = 1;
  localparam int CFG_TEN = 2;
  localparam int CFG_SS = 3;
  localparam int CFG_PINS = 4;

  // Header of the first byte of a 10-bit address
  localparam logic [4:0] ADDR10_HDR = 5'h1e;

  // Bits in a byte, the reset value, and the pin direction the port needs
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] PIN_DIR_IN = 2'h3;

  // Byte phases within a transfer
  localparam logic [1:0] PH_HI = 2'h0;
  localparam logic [1:0] PH_LO = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;

  // Link engine states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RECV = 5'h02,
    ST_ACK = 5'h04,
    ST_SEND = 5'h08,
    ST_SKIP = 5'h10
  } tws_state_t;

endpackage

// File: rtl/tws_i2c_slave.sv
module tws_i2c_slave (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic LINK_CLK,
  input wire logic PORT_ENABLE,
  input wire logic [3:0] MODE,
  input wire logic [1:0] PIN_DIR,
  input wire logic ADDR_WR,
  input wire logic [7:0] ADDR_WDATA,
  input wire logic TX_WR,
  input wire logic [7:0] TX_WDATA,
  input wire logic BUF_RD,
  input wire logic OVF_CLR,
  input wire logic IRQ_CLR,
  output logic [7:0] RX_BUF,
  output logic BUF_FULL,
  output logic OVERFLOW,
  output logic UPDATE_ADDR,
  output logic PORT_IRQ,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // System domain
  logic [tws_pkg::CFG_W-1:0] cfg; // Mode decode, held stable for crossing
  logic [7:0] addr_reg; // Slave address register
  logic addr_tgl; // Flips on each address write
  logic [7:0] tx_reg; // Byte to send as transmitter
  logic tx_tgl; // Flips on each transmit write
  logic ev_m, ev_s, ev_d; // Event toggle synchroniser
  logic ev_hit; // One system cycle per link event

  // Link domain
  logic [tws_pkg::CFG_W-1:0] cfg_m, cfg_s;
  logic bf_m, bf_s, ov_m, ov_s; // Buffer state seen by the link
  logic at_m, at_s, at_d; // Address write toggle synchroniser
  logic tt_m, tt_s, tt_d; // Transmit write toggle synchroniser
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d; // Bus pins
  logic [7:0] addr_l; // Link copy of the address
  logic [7:0] tx_hold; // Link copy of the transmit byte
  logic act, ten_bit, ss_irq; // Decoded configuration
  logic scl_rise, scl_fall, start_c, stop_c, addr_new;
  tws_pkg::tws_state_t state;
  logic [1:0] phase; // Which byte of the transfer
  logic [3:0] bit_cnt;
  logic [7:0] shreg; // Shift register
  logic [7:0] tx_sh; // Outgoing shift register
  logic ack_go; // Acknowledge this byte
  logic ten_match; // Both 10-bit address bytes matched
  logic hold; // Clock held low for address update
  logic next_sda_oe;
  logic ev_tgl, ev_load, ev_ovf, ev_ua; // Event to the system side
  logic [7:0] ev_data;

  // Address compare; high byte checks bits 7:1 only
  function automatic logic addr_hit(input logic [1:0] ph, input logic ten,
                                    input logic [7:0] sh, input logic [7:0] a);
    logic hit;
    hit = 1'b1;
    if (ph == tws_pkg::PH_HI) begin
      hit = (sh[7:1] == a[7:1]) && (!ten || sh[7:3] == tws_pkg::ADDR10_HDR);
    end else if (ph == tws_pkg::PH_LO) begin
      hit = (sh == a);
    end
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // System domain

  // Mode decode; only slave modes run the engine here
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg <= '0;
    end else begin
      cfg[tws_pkg::CFG_EN] <= PORT_ENABLE;
      cfg[tws_pkg::CFG_SLAVE] <= (MODE == tws_pkg::MODE_SLV7) ||
                                 (MODE == tws_pkg::MODE_SLV10) ||
                                 (MODE == tws_pkg::MODE_SLV7_SS) ||
                                 (MODE == tws_pkg::MODE_SLV10_SS);
      cfg[tws_pkg::CFG_TEN] <= (MODE == tws_pkg::MODE_SLV10) ||
                               (MODE == tws_pkg::MODE_SLV10_SS);
      cfg[tws_pkg::CFG_SS] <= (MODE == tws_pkg::MODE_SLV7_SS) ||
                              (MODE == tws_pkg::MODE_SLV10_SS);
      cfg[tws_pkg::CFG_PINS] <= (PIN_DIR == tws_pkg::PIN_DIR_IN);
    end
  end

  // Address and transmit registers; data stays stable until next write
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      addr_reg <= tws_pkg::BYTE_ZERO;
      addr_tgl <= 1'b0;
      tx_reg <= tws_pkg::BYTE_ZERO;
      tx_tgl <= 1'b0;
    end else begin
      if (ADDR_WR) begin
        addr_reg <= ADDR_WDATA;
        addr_tgl <= ~addr_tgl;
      end
      if (TX_WR) begin
        tx_reg <= TX_WDATA;
        tx_tgl <= ~tx_tgl;
      end
    end
  end

  // Event toggle from the link; its data fields are stable by now
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ev_m <= 1'b0;
      ev_s <= 1'b0;
      ev_d <= 1'b0;
    end else begin
      ev_m <= ev_tgl;
      ev_s <= ev_m;
      ev_d <= ev_s;
    end
  end
  assign ev_hit = ev_s ^ ev_d;

  // Receive buffer and full flag; a load wins over a read
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RX_BUF <= tws_pkg::BYTE_ZERO;
      BUF_FULL <= 1'b0;
    end else if (ev_hit && ev_load) begin
      RX_BUF <= ev_data;
      BUF_FULL <= 1'b1;
    end else if (BUF_RD) begin
      BUF_FULL <= 1'b0;
    end
  end

  // Sticky flags; set wins over the clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      OVERFLOW <= 1'b0;
      PORT_IRQ <= 1'b0;
      UPDATE_ADDR <= 1'b0;
    end else begin
      if (ev_hit && ev_ovf) OVERFLOW <= 1'b1;
      else if (OVF_CLR) OVERFLOW <= 1'b0;
      if (ev_hit) PORT_IRQ <= 1'b1;
      else if (IRQ_CLR) PORT_IRQ <= 1'b0;
      if (ev_hit && ev_ua) UPDATE_ADDR <= 1'b1;
      else if (ADDR_WR) UPDATE_ADDR <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: synchronisers

  // Two flops on every pin and level; the first flop feeds only the second
  always_ff @(posedge LINK_CLK or negedge RST_B) begin
    if (!RST_B) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {cfg_m, cfg_s} <= '0;
      {bf_m, bf_s, ov_m, ov_s} <= 4'h0;
      {at_m, at_s, at_d, tt_m, tt_s, tt_d} <= 6'h00;
    end else begin
      scl_m <= SCL_I;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= SDA_I;
      sda_s <= sda_m;
      sda_d <= sda_s;
      cfg_m <= cfg;
      cfg_s <= cfg_m;
      bf_m <= BUF_FULL;
      bf_s <= bf_m;
      ov_m <= OVERFLOW;
      ov_s <= ov_m;
      at_m <= addr_tgl;
      at_s <= at_m;
      at_d <= at_s;
      tt_m <= tx_tgl;
      tt_s <= tt_m;
      tt_d <= tt_s;
    end
  end

  assign act = cfg_s[tws_pkg::CFG_EN] && cfg_s[tws_pkg::CFG_SLAVE] &&
               cfg_s[tws_pkg::CFG_PINS];
  assign ten_bit = cfg_s[tws_pkg::CFG_TEN];
  assign ss_irq = cfg_s[tws_pkg::CFG_SS];
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_c = scl_s && scl_d && sda_d && !sda_s;
  assign stop_c = scl_s && scl_d && !sda_d && sda_s;
  assign addr_new = at_s ^ at_d;

  // Local copies of the written words, taken once their toggle has landed
  always_ff @(posedge LINK_CLK or negedge RST_B) begin
    if (!RST_B) begin
      addr_l <= tws_pkg::BYTE_ZERO;
      tx_hold <= tws_pkg::BYTE_ZERO;
    end else begin
      if (addr_new) addr_l <= addr_reg;
      if (tt_s ^ tt_d) tx_hold <= tx_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: protocol engine

  // Full/overflow are seen a few link cycles late; a byte is far longer
  always_ff @(posedge LINK_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= tws_pkg::ST_IDLE;
      phase <= tws_pkg::PH_HI;
      bit_cnt <= '0;
      shreg <= tws_pkg::BYTE_ZERO;
      tx_sh <= tws_pkg::BYTE_ZERO;
      ack_go <= 1'b0;
      ten_match <= 1'b0;
      ev_tgl <= 1'b0;
      {ev_load, ev_ovf, ev_ua} <= 3'h0;
      ev_data <= tws_pkg::BYTE_ZERO;
    end else if (!act) begin
      state <= tws_pkg::ST_IDLE;
      ten_match <= 1'b0;
    end else if (stop_c || start_c) begin
      state <= stop_c ? tws_pkg::ST_IDLE : tws_pkg::ST_RECV;
      phase <= tws_pkg::PH_HI;
      bit_cnt <= '0;
      if (stop_c) ten_match <= 1'b0;
      if (ss_irq) begin
        {ev_load, ev_ovf, ev_ua} <= 3'h0;
        ev_tgl <= ~ev_tgl;
      end
    end else begin
      case (state)
        tws_pkg::ST_RECV: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == tws_pkg::BYTE_BITS) begin
            if (addr_hit(phase, ten_bit, shreg, addr_l)) begin
              ack_go <= !bf_s && !ov_s;
              state <= tws_pkg::ST_ACK;
            end else begin
              state <= tws_pkg::ST_SKIP;
            end
          end
        end
        tws_pkg::ST_ACK: begin
          if (scl_fall) begin
            // Ninth falling edge: report the byte and pick what follows
            ev_data <= shreg;
            ev_load <= ack_go;
            ev_ovf <= !ack_go;
            ev_ua <= ten_bit && !ten_match && phase != tws_pkg::PH_DATA;
            ev_tgl <= ~ev_tgl;
            bit_cnt <= '0;
            tx_sh <= tx_hold;
            state <= tws_pkg::ST_RECV;
            if (phase == tws_pkg::PH_LO) begin
              ten_match <= 1'b1;
              phase <= tws_pkg::PH_DATA;
            end else if (phase == tws_pkg::PH_HI && ten_bit && !ten_match) begin
              phase <= tws_pkg::PH_LO;
            end else if (phase == tws_pkg::PH_HI) begin
              phase <= tws_pkg::PH_DATA;
              if (shreg[0]) state <= tws_pkg::ST_SEND;
            end
          end
        end
        tws_pkg::ST_SEND: begin
          if (scl_rise && bit_cnt == tws_pkg::BYTE_BITS) begin
            ack_go <= !sda_s; // Master acknowledge
          end else if (scl_fall && bit_cnt == tws_pkg::BYTE_BITS) begin
            bit_cnt <= '0;
            tx_sh <= tx_hold;
            if (!ack_go) state <= tws_pkg::ST_SKIP; // Master is done
          end else if (scl_fall) begin
            tx_sh <= {tx_sh[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        tws_pkg::ST_SKIP, tws_pkg::ST_IDLE: begin
          bit_cnt <= '0; // Wait for the next start
        end
        default: begin
          state <= tws_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Clock hold after a 10-bit address byte until software reloads the address
  always_ff @(posedge LINK_CLK or negedge RST_B) begin
    if (!RST_B) begin
      hold <= 1'b0;
    end else if (!act || addr_new) begin
      hold <= 1'b0;
    end else if (state == tws_pkg::ST_ACK && scl_fall && ten_bit && !ten_match &&
                 phase != tws_pkg::PH_DATA) begin
      hold <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: pin drivers

  // Low only while acknowledging or sending a zero
  always_comb begin
    next_sda_oe = act && ((state == tws_pkg::ST_ACK && ack_go) ||
                          (state == tws_pkg::ST_SEND && bit_cnt != tws_pkg::BYTE_BITS &&
                           !tx_sh[7]));
  end

  // Open drain: the level is always low, only the enable moves
  always_ff @(posedge LINK_CLK or negedge RST_B) begin
    if (!RST_B) begin
      SDA_OE <= 1'b0;
      SCL_OE <= 1'b0;
      SDA_O <= 1'b0;
      SCL_O <= 1'b0;
    end else begin
      SDA_OE <= next_sda_oe;
      SCL_OE <= act && hold;
      SDA_O <= 1'b0;
      SCL_O <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_pins_low_only: assert property (@(posedge LINK_CLK) disable iff (!RST_B)
    !SDA_O && !SCL_O) else $error("bus pin driven high");
  a_off_no_drive: assert property (@(posedge LINK_CLK) disable iff (!RST_B)
    !act |=> !SDA_OE && !SCL_OE) else $error("pins driven while off");
  a_ack_withheld: assert property (@(posedge LINK_CLK) disable iff (!RST_B)
    (state == tws_pkg::ST_ACK && !ack_go) |=> !SDA_OE) else $error("ack not withheld");
  a_shift_on_rise: assert property (@(posedge LINK_CLK) disable iff (!RST_B)
    (act && !start_c && !stop_c && state == tws_pkg::ST_RECV && scl_rise)
    |=> shreg[0] == $past(sda_s)) else $error("bit not shifted in");
  a_compare_eighth: assert property (@(posedge LINK_CLK) disable iff (!RST_B)
    (act && !start_c && !stop_c && state == tws_pkg::ST_RECV && scl_fall &&
     bit_cnt == tws_pkg::BYTE_BITS) |=> state inside {tws_pkg::ST_ACK, tws_pkg::ST_SKIP})
    else $error("no compare on eighth fall");
  a_hold_stretch: assert property (@(posedge LINK_CLK) disable iff (!RST_B)
    $rose(hold) |=> SCL_OE) else $error("clock not held");
  a_buf_load: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (ev_hit && ev_load) |=> BUF_FULL && RX_BUF == $past(ev_data)) else $error("no load");
  a_buf_kept: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (ev_hit && !ev_load) |=> RX_BUF == $past(RX_BUF) && PORT_IRQ)
    else $error("buffer changed on refusal");
  a_read_clears: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (BUF_RD && !(ev_hit && ev_load)) |=> !BUF_FULL) else $error("full not cleared");
  a_ovf_sticky: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (OVERFLOW && !OVF_CLR) |=> OVERFLOW) else $error("overflow lost");
  a_ua_release: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (ADDR_WR && !(ev_hit && ev_ua)) |=> !UPDATE_ADDR) else $error("update flag stuck");

  c_byte_loaded: cover property (@(posedge SYS_CLK) disable iff (!RST_B) ev_hit && ev_load);
  c_byte_refused: cover property (@(posedge SYS_CLK) disable iff (!RST_B) ev_hit && ev_ovf);
  c_ten_bit_hold: cover property (@(posedge LINK_CLK) disable iff (!RST_B) $rose(hold));
  c_transmit: cover property (@(posedge LINK_CLK) disable iff (!RST_B)
    state == tws_pkg::ST_SEND && scl_fall);

endmodule

// File: tb/tws_bus_master.sv
module tws_bus_master (
  output logic scl_low,
  output logic sda_low,
  input wire logic scl_w,
  input wire logic sda_w,
  output logic hang
);
  timeunit 1ns;
  timeprecision 1ps;

  // Half of one bus clock period, well above the synchroniser delay
  localparam int HALF = 200;

  // Lines start released; the pull-ups hold them high
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hang = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Release the clock and wait while the slave stretches it, with a bound
  task automatic rel_scl();
    int n;
    scl_low = 1'b0;
    n = 0;
    while (scl_w !== 1'b1 && n < 4000) begin
      #10;
      n++;
    end
    // A slave that never lets go is reported, not waited on forever
    if (n >= 4000) hang = 1'b1;
    #HALF;
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start();
    sda_low = 1'b0;
    #HALF;
    rel_scl();
    sda_low = 1'b1;
    #HALF;
    scl_low = 1'b1;
    #HALF;
  endtask

  // Stop: data rises while the clock is high
  task automatic stop();
    sda_low = 1'b1;
    #HALF;
    rel_scl();
    sda_low = 1'b0;
    #HALF;
  endtask

  // Eight bits, most significant first, then the ninth clock for the ack
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      #HALF;
      rel_scl();
      scl_low = 1'b1;
    end
    sda_low = 1'b0;
    #HALF;
    scl_low = 1'b0;
    #HALF;
    ack = (sda_w === 1'b0);
    scl_low = 1'b1;
    #HALF;
  endtask

  // Read eight bits from the slave, then answer with ack or nack
  task automatic rd_byte(output logic [7:0] b, input logic nack);
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #HALF;
      scl_low = 1'b0;
      #HALF;
      b[i] = sda_w;
      scl_low = 1'b1;
    end
    sda_low = ~nack;
    #HALF;
    rel_scl();
    scl_low = 1'b1;
    #HALF;
    sda_low = 1'b0;
  endtask
endmodule

// File: tb/tb_i2c_slave_address_receiver.sv
module tb_i2c_slave_address_receiver;
  timeunit 1ns;
  timeprecision 1ps;

  // One row: configuration, address byte sent, expected answer
  typedef struct {
    logic en;
    logic [3:0] mode;
    logic [1:0] pd;
    logic [7:0] adr;
    logic [7:0] byt;
    logic ack;
    logic irq;
    logic fl;
  } tws_row_t;

  logic SYS_CLK, LINK_CLK, RST_B, PORT_ENABLE, ADDR_WR, TX_WR, BUF_RD, OVF_CLR, IRQ_CLR;
  logic [3:0] MODE;
  logic [1:0] PIN_DIR;
  logic [7:0] ADDR_WDATA, TX_WDATA, RX_BUF, last_rx, rb;
  logic BUF_FULL, OVERFLOW, UPDATE_ADDR, PORT_IRQ, SCL_O, SCL_OE, SDA_O, SDA_OE;
  logic m_scl, m_sda, m_hang, ack;
  wire scl_w, sda_w;
  int n_errors = 0;
  int checks_done = 0;

  // Open-drain wires with pull-ups: low while any party pulls
  assign scl_w = ~(m_scl | SCL_OE);
  assign sda_w = ~(m_sda | SDA_OE);

  tws_i2c_slave dut_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .LINK_CLK(LINK_CLK),
    .PORT_ENABLE(PORT_ENABLE), .MODE(MODE), .PIN_DIR(PIN_DIR), .ADDR_WR(ADDR_WR),
    .ADDR_WDATA(ADDR_WDATA), .TX_WR(TX_WR), .TX_WDATA(TX_WDATA), .BUF_RD(BUF_RD),
    .OVF_CLR(OVF_CLR), .IRQ_CLR(IRQ_CLR), .RX_BUF(RX_BUF), .BUF_FULL(BUF_FULL),
    .OVERFLOW(OVERFLOW), .UPDATE_ADDR(UPDATE_ADDR), .PORT_IRQ(PORT_IRQ), .SCL_I(scl_w),
    .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(sda_w), .SDA_O(SDA_O), .SDA_OE(SDA_OE));

  tws_bus_master m_u (.scl_low(m_scl), .sda_low(m_sda), .scl_w(scl_w), .sda_w(sda_w),
    .hang(m_hang));

  // Ordinary cases; the A2 rows differ from the address only in bit 1
  tws_row_t rows [9] = '{
    '{1'b1, 4'h6, 2'h3, 8'hA0, 8'hA0, 1'b1, 1'b1, 1'b1},
    '{1'b1, 4'h6, 2'h3, 8'hA0, 8'hA2, 1'b0, 1'b0, 1'b1},
    '{1'b0, 4'h6, 2'h3, 8'hA0, 8'hA0, 1'b0, 1'b0, 1'b1},
    '{1'b1, 4'h6, 2'h1, 8'hA0, 8'hA0, 1'b0, 1'b0, 1'b0},
    '{1'b1, 4'h8, 2'h3, 8'hA0, 8'hA0, 1'b0, 1'b0, 1'b1},
    '{1'b1, 4'hB, 2'h3, 8'hA0, 8'hA0, 1'b0, 1'b0, 1'b1},
    '{1'b1, 4'hE, 2'h3, 8'hA0, 8'hA2, 1'b0, 1'b1, 1'b1},
    '{1'b1, 4'hF, 2'h3, 8'hA0, 8'hA0, 1'b0, 1'b1, 1'b1},
    '{1'b1, 4'hE, 2'h3, 8'h7E, 8'h7E, 1'b1, 1'b1, 1'b1}};

  ////////////////////////////////////////////////////////////////////////////////
  // Clocks: link clock unrelated in phase to the system clock
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    LINK_CLK = 1'b0;
    #3;
    forever #6 LINK_CLK = ~LINK_CLK;
  end

  // Pins are only ever pulled low, never driven high
  always @(negedge LINK_CLK) begin
    if (RST_B === 1'b1 && (SCL_OE === 1'b1 || SDA_OE === 1'b1)) begin
      chk("pin_out", {SCL_O, SDA_O}, 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  // Nine bits wide so that an acknowledge bit can travel beside a whole byte
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge SYS_CLK);
  endtask

  // One-cycle software pulses: address write, tx write, read, clears
  task automatic sw(input logic a, input logic t, input logic r, input logic o, input logic i);
    @(negedge SYS_CLK);
    {ADDR_WR, TX_WR, BUF_RD, OVF_CLR, IRQ_CLR} = {a, t, r, o, i};
    @(negedge SYS_CLK);
    {ADDR_WR, TX_WR, BUF_RD, OVF_CLR, IRQ_CLR} = 5'h00;
  endtask

  // Flags after a byte: full, interrupt, update
  task automatic flags(input logic bf, input logic irq, input logic ua);
    chk("flags", {BUF_FULL, PORT_IRQ, UPDATE_ADDR}, {bf, irq, ua});
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard: a run this long counts as a failure
  initial begin
    #3_000_000;
    n_errors++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {RST_B, PORT_ENABLE, ADDR_WR, TX_WR, BUF_RD, OVF_CLR, IRQ_CLR} = 7'h00;
    MODE = 4'h6;
    PIN_DIR = tws_pkg::PIN_DIR_IN;
    ADDR_WDATA = 8'h00;
    TX_WDATA = 8'h00;
    last_rx = tws_pkg::BYTE_ZERO;
    cyc(16);
    RST_B = 1'b1;
    cyc(2);
    chk("reset", {RX_BUF}, 8'h00);
    chk("reset_fl", {OVERFLOW, BUF_FULL, PORT_IRQ, UPDATE_ADDR, SCL_OE, SDA_OE}, 8'h00);
    // Row loop: enable, mode field, pin direction and address compare
    foreach (rows[k]) begin
      {PORT_ENABLE, MODE, PIN_DIR, ADDR_WDATA} = {rows[k].en, rows[k].mode, rows[k].pd, rows[k].adr};
      sw(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      cyc(10);
      m_u.start();
      m_u.wr_byte(rows[k].byt, ack);
      cyc(8);
      if (rows[k].ack) last_rx = rows[k].byt;
      chk("ack", ack, rows[k].ack);
      if (rows[k].fl) begin
        flags(rows[k].ack, rows[k].irq, 1'b0);
        chk("rx_buf", RX_BUF, last_rx);
      end
      m_u.stop();
      cyc(8);
      sw(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      cyc(2);
    end
    // Data after a match, then refusal while full and while overflowed
    {PORT_ENABLE, MODE, PIN_DIR, ADDR_WDATA} = {1'b1, 4'h6, 2'h3, 8'hA0};
    sw(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    cyc(10);
    m_u.start();
    m_u.wr_byte(8'hA0, ack);
    sw(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    m_u.wr_byte(8'h3C, ack);
    cyc(8);
    chk("data_ack", {ack, RX_BUF}, 9'h13C);
    sw(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    m_u.wr_byte(8'h99, ack);
    cyc(8);
    chk("full_nack", {ack, RX_BUF}, 8'h3C);
    chk("full_fl", {PORT_IRQ, OVERFLOW}, 2'h3);
    sw(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    chk("rd_clr", {BUF_FULL, OVERFLOW}, 2'h1);
    m_u.stop();
    m_u.start();
    m_u.wr_byte(8'hA0, ack);
    cyc(8);
    chk("ovf_nack", {ack, RX_BUF}, 8'h3C);
    m_u.stop();
    sw(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    chk("ovf_clr", OVERFLOW, 1'b0);
    // Ten-bit address: high byte, low byte, repeated start and read
    {MODE, ADDR_WDATA, TX_WDATA} = {tws_pkg::MODE_SLV10, 8'hF2, 8'hC5};
    sw(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    cyc(10);
    m_u.start();
    m_u.wr_byte(8'hF2, ack);
    cyc(8);
    chk("hi_ack", {ack, SCL_OE}, 2'h3);
    flags(1'b1, 1'b1, 1'b1);
    ADDR_WDATA = 8'h5A;
    sw(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    cyc(4);
    chk("hi_rel", {UPDATE_ADDR, SCL_OE}, 2'h0);
    m_u.wr_byte(8'h5A, ack);
    cyc(8);
    chk("lo_ack", {ack, SCL_OE}, 2'h3);
    flags(1'b1, 1'b1, 1'b1);
    ADDR_WDATA = 8'hF2;
    sw(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    cyc(4);
    chk("lo_rel", {UPDATE_ADDR, SCL_OE}, 2'h0);
    m_u.start();
    m_u.wr_byte(8'hF3, ack);
    cyc(8);
    chk("rs_ack", ack, 1'b1);
    flags(1'b1, 1'b1, 1'b0);
    m_u.rd_byte(rb, 1'b1);
    chk("tx_byte", rb, 8'hC5);
    m_u.stop();
    cyc(4);
    // Second reset in mid-run clears every flag
    RST_B = 1'b0;
    cyc(4);
    chk("reset2", {BUF_FULL, PORT_IRQ, UPDATE_ADDR, OVERFLOW, SCL_OE, SDA_OE}, 8'h00);
    RST_B = 1'b1;
    cyc(4);
    chk("stretch", m_hang, 1'b0);
    end_sim();
  end
endmodule
